// ---- acsc_top.sv ----
// Conversion timing, sync trigger phase reset and register access for sixteen converter cores.
`timescale 1ns/1ps
`include "acsc_defines.svh"

module acsc_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sync_trigger_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire acsc_pkg::acsc_samples_t sample_in,
    output acsc_pkg::acsc_raw_t raw_conversion_word_out,
    output acsc_pkg::acsc_proc_t processed_word_out,
    output acsc_pkg::acsc_sel_t analog_input_sel_out,
    output logic conv_tick_out,
    output logic frame_clk_out,
    output logic sample_even_out,
    output logic word_valid_out
);
    import acsc_pkg::*;

    logic sync_s1_ff;
    logic sync_s2_ff;
    logic sync_s3_ff;
    logic sync_pulse;
    logic phase_rst;

    acsc_ctrl_t ctrl_ff;
    acsc_ctrl_t nxt_ctrl;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic sync_seen_ff;
    logic nxt_sync_seen;
    acsc_status_t status;
    logic acc_phase;
    logic addr_ok;

    acsc_mode_t eff_mode;
    acsc_res_t eff_res;
    logic cfg_err;

    logic div_ff;
    logic nxt_div;
    logic even_ff;
    logic nxt_even;
    logic [2:0] frame_ff;
    logic [2:0] nxt_frame;
    logic [15:0] pat_ff;
    logic [15:0] nxt_pat;
    logic [2:0] blank_ff;
    logic [2:0] nxt_blank;
    logic valid_ff;
    logic tick_ff;
    logic tick;
    logic [15:0] conv_en;

    acsc_proc_t core_word;
    acsc_proc_t proc_ff;
    acsc_proc_t nxt_proc;

    ////////////////////////////////////////////////////////////////////////////////
    // The trigger pin is asynchronous to the system clock, so it passes two flops before any use.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync_s1_ff <= 1'b0;
            sync_s2_ff <= 1'b0;
            sync_s3_ff <= 1'b0;
        end else begin
            sync_s1_ff <= sync_trigger_in;
            sync_s2_ff <= sync_s1_ff;
            sync_s3_ff <= sync_s2_ff;
        end
    end

    assign sync_pulse = sync_s2_ff & ~sync_s3_ff;
    assign phase_rst = sync_pulse & ~ctrl_ff.mask;

    ////////////////////////////////////////////////////////////////////////////////
    // Illegal codes fall back to 16-input mode and 14 bits (10 bits in 8-input mode) and raise the configuration error flag.
    always_comb begin
        eff_mode = ACSC_MODE_16;
        eff_res = ACSC_RES_14;
        unique case (ctrl_ff.mode)
            2'h1: eff_mode = ACSC_MODE_32;
            2'h2: eff_mode = ACSC_MODE_8;
            default: eff_mode = ACSC_MODE_16;
        endcase
        unique case (ctrl_ff.res)
            2'h0: eff_res = ACSC_RES_10;
            2'h1: eff_res = ACSC_RES_12;
            default: eff_res = ACSC_RES_14;
        endcase
        if (eff_mode == ACSC_MODE_8) begin
            eff_res = ACSC_RES_10;
        end
    end

    assign cfg_err = (ctrl_ff.mode == 2'h3) || (ctrl_ff.res == 2'h3)
        || ((eff_mode == ACSC_MODE_8) && (ctrl_ff.res != 2'h0));

    ////////////////////////////////////////////////////////////////////////////////
    assign tick = (eff_mode != ACSC_MODE_8) || !div_ff;

    always_comb begin
        nxt_div = div_ff;
        nxt_even = even_ff;
        nxt_frame = frame_ff;
        nxt_pat = pat_ff;
        nxt_blank = blank_ff;
        if (phase_rst) begin
            nxt_div = 1'b0;
            nxt_even = 1'b0;
            nxt_frame = 3'h0;
            nxt_pat = 16'h0000;
            nxt_blank = `ACSC_BLANK_CYC;
        end else begin
            nxt_div = (eff_mode == ACSC_MODE_8) ? ~div_ff : 1'b0;
            if ((eff_mode != ACSC_MODE_8) || div_ff) begin
                nxt_even = ~even_ff;
            end
            if (tick) begin
                nxt_frame = (frame_ff == `ACSC_FRAME_LEN) ? 3'h0 : frame_ff + 3'h1;
                nxt_pat = pat_ff + 16'h0001;
            end
            if (blank_ff != 3'h0) begin
                nxt_blank = blank_ff - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            div_ff <= 1'b0;
            even_ff <= 1'b0;
            frame_ff <= 3'h0;
            pat_ff <= 16'h0000;
            blank_ff <= 3'h0;
            valid_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            even_ff <= nxt_even;
            frame_ff <= nxt_frame;
            pat_ff <= nxt_pat;
            blank_ff <= nxt_blank;
            valid_ff <= (nxt_blank == 3'h0);
            tick_ff <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // In 8-input mode the even core of a pair converts on divider phase 0 and its partner on phase 1.
    genvar k;
    generate
        for (k = 0; k < 16; k++) begin : g_core
            assign conv_en[k] = (eff_mode != ACSC_MODE_8) || (div_ff == 1'(k % 2));

            acsc_core #(
                .CORE_IDX(k)
            ) u_core (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .conv_en_in(conv_en[k]),
                .sample_in(sample_in[k]),
                .mode_in(eff_mode),
                .even_in(even_ff),
                .res_in(eff_res),
                .bypass_in(ctrl_ff.bypass),
                .raw_word_out(raw_conversion_word_out[k]),
                .proc_word_out(core_word[k]),
                .sel_out(analog_input_sel_out[k])
            );

            assign nxt_proc[k] = ctrl_ff.test_pat_en ? pat_ff : core_word[k];
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            proc_ff <= '0;
        end else begin
            proc_ff <= nxt_proc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign acc_phase = psel_in & penable_in;
    assign addr_ok = (paddr_in == `ACSC_OFF_CTRL) || (paddr_in == `ACSC_OFF_STATUS);

    always_comb begin
        status.frame_phase = frame_ff;
        status.word_valid = valid_ff;
        status.sample_even = even_ff;
        status.conv_phase = div_ff;
        status.cfg_err = cfg_err;
        status.sync_seen = sync_seen_ff;
    end

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_rdata = rdata_ff;
        nxt_sync_seen = sync_seen_ff | sync_pulse;
        if (acc_phase && pwrite_in && (paddr_in == `ACSC_OFF_CTRL)) begin
            nxt_ctrl.mode = pwdata_in[`ACSC_CTRL_MODE_LSB +: 2];
            nxt_ctrl.res = pwdata_in[`ACSC_CTRL_RES_LSB +: 2];
            nxt_ctrl.mask = pwdata_in[`ACSC_CTRL_MASK_BIT];
            nxt_ctrl.bypass = pwdata_in[`ACSC_CTRL_BYPASS_BIT];
            nxt_ctrl.test_pat_en = pwdata_in[`ACSC_CTRL_PAT_BIT];
        end
        // Read data is captured in the setup cycle so the access phase can finish at once.
        if (psel_in && !penable_in) begin
            if (paddr_in == `ACSC_OFF_CTRL) begin
                nxt_rdata = {25'h0000000, ctrl_ff};
            end else if (paddr_in == `ACSC_OFF_STATUS) begin
                nxt_rdata = {24'h000000, status};
            end else begin
                nxt_rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_ff <= `ACSC_CTRL_RST;
            rdata_ff <= 32'h00000000;
            sync_seen_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
            sync_seen_ff <= nxt_sync_seen;
        end
    end

    assign prdata_out = rdata_ff;
    assign pready_out = 1'b1;
    assign pslverr_out = acc_phase & ~addr_ok;

    ////////////////////////////////////////////////////////////////////////////////
    assign processed_word_out = proc_ff;
    assign conv_tick_out = tick_ff;
    assign frame_clk_out = (frame_ff < 3'h4);
    assign sample_even_out = even_ff;
    assign word_valid_out = valid_ff;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_trig_then_quiet;
        phase_rst ##1 (!phase_rst) [*6];
    endsequence

    a_phase_reset_state: assert property (phase_rst |=> (!div_ff && !even_ff && frame_ff == 3'h0))
        else $error("Phase state not cleared after trigger.");
    a_blank_window: assert property (phase_rst |=> (!valid_ff) [*6])
        else $error("Word valid rose inside the blanking window.");
    a_blank_release: assert property (s_trig_then_quiet |=> valid_ff)
        else $error("Word valid did not return after blanking.");
    a_mask_blocks: assert property (sync_pulse && ctrl_ff.mask && valid_ff |=> valid_ff)
        else $error("Masked trigger started a phase reset.");
    a_div_toggle: assert property (eff_mode == ACSC_MODE_8 && !phase_rst |=> div_ff != $past(div_ff))
        else $error("Divider did not toggle in 8-input mode.");
    a_even_lag: assert property (eff_mode == ACSC_MODE_32 && !even_ff && !phase_rst |=> even_ff)
        else $error("Even instant did not follow odd by one clock.");
    a_full_rate: assert property (eff_mode != ACSC_MODE_8 |-> conv_en == 16'hFFFF)
        else $error("A core skipped a conversion at full rate.");
    a_res_forced: assert property (eff_mode == ACSC_MODE_8 |-> eff_res == ACSC_RES_10)
        else $error("8-input mode not held at 10 bits.");
    a_trig_pulse: assert property ($rose(sync_s2_ff) |-> sync_pulse ##1 !sync_pulse)
        else $error("Trigger edge gave no single pulse.");

endmodule

// ---- acsc_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the conversion sync control.
`ifndef ACSC_DEFINES_SVH
`define ACSC_DEFINES_SVH

`define ACSC_OFF_CTRL 12'h000
`define ACSC_OFF_STATUS 12'h004

`define ACSC_CTRL_MODE_LSB 0
`define ACSC_CTRL_RES_LSB 2
`define ACSC_CTRL_MASK_BIT 4
`define ACSC_CTRL_BYPASS_BIT 5
`define ACSC_CTRL_PAT_BIT 6
`define ACSC_CTRL_RST 7'h00

`define ACSC_BLANK_CYC 3'h6
`define ACSC_FRAME_LEN 3'h7
`define ACSC_PROC_LAT 2

`endif

// ---- acsc_pkg.sv ----
// Types shared by the conversion sync control modules.
package acsc_pkg;

    typedef enum logic [1:0] {ACSC_MODE_16, ACSC_MODE_32, ACSC_MODE_8} acsc_mode_t;
    typedef enum logic [1:0] {ACSC_RES_10, ACSC_RES_12, ACSC_RES_14} acsc_res_t;

    typedef struct packed {
        logic test_pat_en;
        logic bypass;
        logic mask;
        logic [1:0] res;
        logic [1:0] mode;
    } acsc_ctrl_t;

    typedef struct packed {
        logic [2:0] frame_phase;
        logic word_valid;
        logic sample_even;
        logic conv_phase;
        logic cfg_err;
        logic sync_seen;
    } acsc_status_t;

    typedef logic [15:0][13:0] acsc_samples_t;
    typedef logic [15:0][13:0] acsc_raw_t;
    typedef logic [15:0][15:0] acsc_proc_t;
    typedef logic [15:0][4:0] acsc_sel_t;

endpackage

// ---- acsc_core.sv ----
// One converter core: sample capture, resolution trim and output word formatting.
`timescale 1ns/1ps
`include "acsc_defines.svh"

module acsc_core #(
    parameter int CORE_IDX = 0
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic conv_en_in,
    input wire logic [13:0] sample_in,
    input wire acsc_pkg::acsc_mode_t mode_in,
    input wire logic even_in,
    input wire acsc_pkg::acsc_res_t res_in,
    input wire logic bypass_in,
    output logic [13:0] raw_word_out,
    output logic [15:0] proc_word_out,
    output logic [4:0] sel_out
);
    import acsc_pkg::*;

    logic [13:0] raw_ff;
    logic [13:0] nxt_raw;
    logic [15:0] word_ff;
    logic [15:0] nxt_word;
    logic [4:0] sel_ff;
    logic [4:0] nxt_sel;
    logic [15:0] pipe_ff [`ACSC_PROC_LAT];
    logic [15:0] nxt_pipe [`ACSC_PROC_LAT];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_raw = raw_ff;
        nxt_word = word_ff;
        nxt_sel = sel_ff;
        if (conv_en_in) begin
            unique case (res_in)
                ACSC_RES_10: begin
                    nxt_raw = {{4{sample_in[13]}}, sample_in[13:4]};
                    nxt_word = {sample_in[13:4], 6'h00};
                end
                ACSC_RES_12: begin
                    nxt_raw = {{2{sample_in[13]}}, sample_in[13:2]};
                    nxt_word = {sample_in[13:2], 4'h0};
                end
                ACSC_RES_14: begin
                    nxt_raw = sample_in;
                    nxt_word = {sample_in, 2'h0};
                end
            endcase
            unique case (mode_in)
                ACSC_MODE_16: nxt_sel = 5'(CORE_IDX);
                ACSC_MODE_32: nxt_sel = 5'(2 * CORE_IDX) + {4'h0, even_in};
                ACSC_MODE_8: nxt_sel = 5'(CORE_IDX / 2);
            endcase
        end
    end

    // The enhancement stages are not fitted; their latency is kept so that bypass still saves it.
    always_comb begin
        nxt_pipe[0] = word_ff;
        for (int i = 1; i < `ACSC_PROC_LAT; i++) begin
            nxt_pipe[i] = pipe_ff[i - 1];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            raw_ff <= 14'h0000;
            word_ff <= 16'h0000;
            sel_ff <= 5'h00;
            for (int i = 0; i < `ACSC_PROC_LAT; i++) begin
                pipe_ff[i] <= 16'h0000;
            end
        end else begin
            raw_ff <= nxt_raw;
            word_ff <= nxt_word;
            sel_ff <= nxt_sel;
            pipe_ff <= nxt_pipe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign raw_word_out = raw_ff;
    assign sel_out = sel_ff;
    assign proc_word_out = bypass_in ? word_ff : pipe_ff[`ACSC_PROC_LAT - 1];

endmodule

// ---- acsc_host_model.sv ----
// Host controller model: drives the sync trigger and tracks the window of samples to be ignored.
`timescale 1ns/1ps

module acsc_host_model (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic fire_in,
    input wire logic [3:0] hold_in,
    output logic sync_trigger_out,
    output logic discard_out
);
    logic [3:0] hold_cnt_ff;
    logic [3:0] discard_cnt_ff;
    logic init_done_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // The first pulse is sent unasked right after reset, because the device is not aligned without it.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            hold_cnt_ff <= 4'h0;
            discard_cnt_ff <= 4'h0;
            init_done_ff <= 1'b0;
        end else if (fire_in || !init_done_ff) begin
            init_done_ff <= 1'b1;
            hold_cnt_ff <= (hold_in == 4'h0) ? 4'h1 : hold_in;
            discard_cnt_ff <= 4'hF;
        end else begin
            if (hold_cnt_ff != 4'h0) begin
                hold_cnt_ff <= hold_cnt_ff - 4'h1;
            end
            if (discard_cnt_ff != 4'h0 && hold_cnt_ff == 4'h0) begin
                discard_cnt_ff <= discard_cnt_ff - 4'h1;
            end
        end
    end

    assign sync_trigger_out = (hold_cnt_ff != 4'h0);
    assign discard_out = (discard_cnt_ff != 4'h0) || (hold_cnt_ff != 4'h0);
endmodule

// ---- acsc_tb_top.sv ----
// Self-checking testbench of the conversion sync control.
`timescale 1ns/1ps

module acsc_tb_top;
    import acsc_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    acsc_samples_t sample = '0;
    acsc_raw_t raw;
    acsc_proc_t proc;
    acsc_sel_t sel;
    logic conv_tick, frame_clk, sample_even, word_valid, trig, discard;
    logic fire = 1'b0;
    logic [3:0] hold = 4'h1;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [6:0] r_ctrl [5] = '{7'h20, 7'h04, 7'h29, 7'h26, 7'h0F};
    logic [13:0] r_samp [5] = '{14'h2ABD, 14'h2ABD, 14'h2ABD, 14'h1235, 14'h1235};
    logic [13:0] r_raw [5] = '{14'h3EAB, 14'h3AAF, 14'h2ABD, 14'h0123, 14'h1235};
    logic [15:0] r_proc [5] = '{16'hAAC0, 16'hAAF0, 16'hAAF4, 16'h48C0, 16'h48D4};
    logic r_err [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    always #5 clk_in = ~clk_in;

    acsc_top u_acsc_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sync_trigger_in(trig), .paddr_in(paddr),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .sample_in(sample), .raw_conversion_word_out(raw),
        .processed_word_out(proc), .analog_input_sel_out(sel), .conv_tick_out(conv_tick),
        .frame_clk_out(frame_clk), .sample_even_out(sample_even), .word_valid_out(word_valid));
    acsc_host_model u_acsc_host_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .fire_in(fire),
        .hold_in(hold), .sync_trigger_out(trig), .discard_out(discard));

    ////////////////////////////////////////////////////////////////////////////////
    task results;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task chk_b(input logic got, input logic exp, input string m);
        chk_w({31'h0, got}, {31'h0, exp}, m);
    endtask

    // A wait that used up its bound is a mismatch and ends the run at once.
    task lim(input int i, input int bound);
        if (i >= bound) begin
            n_mismatch++;
            results();
        end
    endtask

    // Outputs are looked at 1 ns after the edge so that the edge's updates have landed.
    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
        int i;
        @(posedge clk_in);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clk_in);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (pready !== 1'b1 && i < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        lim(i, 16);
    endtask

    task set_ctrl(input logic [6:0] v);
        logic [31:0] r;
        logic e;
        apb(12'h000, 1'b1, {25'h0, v}, r, e);
        chk_b(e, 1'b0, "ctrl write error");
    endtask

    task set_samp(input logic [13:0] v);
        for (int k = 0; k < 16; k++) sample[k] <= v;
    endtask

    // Fires one trigger and measures the blanking and the first frame clock run.
    task pulse(input logic [3:0] h, output int low, output int fhi, output logic ev0, output logic tk0);
        int i;
        logic fdone;
        fire <= 1'b1;
        hold <= h;
        tick(1);
        fire <= 1'b0;
        i = 0;
        fdone = 1'b0;
        while (word_valid === 1'b1 && i < 12) begin
            tick(1);
            i++;
        end
        lim(i, 12);
        ev0 = sample_even;
        tk0 = 1'b0;
        low = 0;
        fhi = 0;
        while (word_valid !== 1'b1 && low < 20) begin
            if (frame_clk === 1'b1 && !fdone) fhi++;
            else fdone = 1'b1;
            // The tick seen at the reset edge still carries the old phase; the next one is fixed by the trigger.
            if (low == 1) tk0 = conv_tick;
            low++;
            tick(1);
        end
        lim(low, 20);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic e, ev, tk, prv, ok;
        int lo, fh, n;
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk_b(word_valid, 1'b0, "valid in reset");
        chk_b(pready, 1'b1, "pready in reset");
        chk_w(32'(raw[0]), 32'h0, "raw in reset");
        tick(1);
        n = 0;
        while (discard !== 1'b0 && n < 40) begin
            tick(1);
            n++;
        end
        lim(n, 40);
        chk_b(word_valid, 1'b1, "valid after init pulse");
        apb(12'h000, 1'b0, 32'h0, r, e);
        chk_w(r, 32'h0, "ctrl reset value");
        apb(12'h008, 1'b0, 32'h0, r, e);
        chk_w({r[31:1], e}, 32'h1, "unmapped read");
        apb(12'h004, 1'b1, 32'hFFFF_FFFF, r, e);
        chk_b(e, 1'b0, "status write error");
        apb(12'h004, 1'b0, 32'h0, r, e);
        chk_w({r[31:8], r[0]}, 25'h1, "status after init pulse");
        for (int i = 0; i < 5; i++) begin
            set_ctrl(r_ctrl[i]);
            set_samp(r_samp[i]);
            tick(8);
            for (int k = 0; k < 16; k++) begin
                chk_w(32'(raw[k]), 32'(r_raw[i]), "raw word");
                chk_w(32'(proc[k]), 32'(r_proc[i]), "processed word");
                chk_w(32'(r_ctrl[i][1:0] == 2'h1 ? sel[k][4:1] : sel[k]), 32'(r_ctrl[i][1:0] == 2'h2 ? k / 2 : k),
                    "input index");
            end
            if (r_ctrl[i][1:0] != 2'h2) chk_b(conv_tick, 1'b1, "tick every clock");
            apb(12'h004, 1'b0, 32'h0, r, e);
            chk_b(r[1], r_err[i], "config error flag");
        end
        for (int b = 1; b >= 0; b--) begin
            set_ctrl(b ? 7'h20 : 7'h00);
            set_samp(14'h0100);
            repeat (8) @(posedge clk_in);
            set_samp(14'h0200);
            #1;
            n = 0;
            while (proc[0] !== 16'h0800 && n < 10) begin
                tick(1);
                n++;
            end
            lim(n, 10);
            chk_w(32'(n), b ? 32'h2 : 32'h4, "processed latency");
        end
        set_ctrl(7'h40);
        pulse(4'h1, lo, fh, ev, tk);
        chk_w(32'(lo), 32'h6, "blanking length");
        chk_w(32'(proc[0]), 32'h5, "pattern phase after trigger");
        chk_w(32'(proc[15]), 32'h5, "pattern on every word");
        chk_w(32'(fh), 32'h4, "frame clock after trigger");
        pulse(4'h4, lo, fh, ev, tk);
        chk_w(32'(lo), 32'h6, "long trigger counted once");
        set_ctrl(7'h01);
        pulse(4'h1, lo, fh, ev, tk);
        chk_b(ev, 1'b0, "odd phase after trigger");
        for (int j = 0; j < 4; j++) begin
            prv = sample_even;
            tick(1);
            chk_b(sample_even, ~prv, "even lags odd by one");
            chk_w(32'(sel[3]), {31'h3, prv}, "pair index follows phase");
        end
        set_ctrl(7'h11);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        ok = 1'b1;
        for (int j = 0; j < 14; j++) begin
            prv = sample_even;
            tick(1);
            ok = ok & word_valid & (sample_even ^ prv);
        end
        chk_b(ok, 1'b1, "masked trigger");
        set_ctrl(7'h02);
        for (int j = 0; j < 3; j++) begin
            tick(j);
            pulse(4'h1, lo, fh, ev, tk);
            chk_b(tk, 1'b1, "divider phase set by trigger");
        end
        for (int j = 0; j < 4; j++) begin
            prv = conv_tick;
            tick(1);
            chk_b(conv_tick, ~prv, "half rate conversion");
        end
        results();
    end
endmodule
